//--- dv/lmcw_checker.sv
`default_nettype none
module lmcw_checker (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic register_select,
   input wire logic chip_en_n,
   input wire logic osc_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] bits_q;
   logic       clk_q;
   // rises per frame mod 8; a short byte leaves a remainder
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bits_q <= 3'h0;
         clk_q  <= 1'b0;
      end else begin
         clk_q  <= ser_clk;
         bits_q <= chip_en_n ? 3'h0 : bits_q + 3'(ser_clk && !clk_q);
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   idle_clk_low_a: assert property (chip_en_n && $past(chip_en_n) |-> !ser_clk)
      else $error("serial clock moved outside a frame");
   select_rs_a: assert property ($fell(chip_en_n) |-> register_select)
      else $error("frame opened without register select");
   rs_stable_a: assert property (!chip_en_n |-> $stable(register_select))
      else $error("register select moved inside a frame");
   clk_high_span_a: assert property ($rose(ser_clk) |-> ser_clk[*5] ##1 !ser_clk)
      else $error("serial clock high phase not five cycles");
   data_hold_a: assert property (ser_clk |-> $stable(ser_data))
      else $error("serial data moved while clock high");
   latch_clk_low_a: assert property ($rose(chip_en_n) |-> !ser_clk ##1 !ser_clk)
      else $error("frame closed with clock high");
   first_rise_a: assert property ($fell(chip_en_n) |-> !ser_clk ##[1:6] $rose(ser_clk))
      else $error("no clock rise after frame open");
   whole_bytes_a: assert property ($rose(chip_en_n) |-> bits_q == 3'h0)
      else $error("frame held a partial byte");
   osc_slow_a: assert property ($changed(osc_out) |=> $stable(osc_out)[*3])
      else $error("oscillator output toggled too fast");
endmodule // lmcw_checker
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import lmcw_pkg::*;
   logic        clk_sys_i, rst_n_i, req, pass, use_ext, lamp;
   logic        ext = 1'b0;
   logic        div = 1'b0;
   logic        busy, done, ser_out, clk_en, row_on, refresh_done;
   logic [2:0]  row;
   logic [7:0]  word;
   logic [31:0] seed;
   logic [6:0]  w0, w1, pct, e0, e1;
   logic [13:0] expq [$];
   int          n_fail, samples_checked, k, ra, rb;
   logic [5:0]  on_t [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09,
                              6'h0B, 6'h0E, 6'h12, 6'h16, 6'h1C, 6'h24, 6'h30, 6'h3C};
   logic [6:0]  pct_t [4] = '{7'h49, 7'h32, 7'h1F, 7'h64};
   lmcw_if link ();
   lmcw_host u_lmcw_host (.clk_sys_i, .rst_n_i, .link(link), .req_i(req), .word_i(word),
      .pass_mode_i(pass), .lamp_off_i(lamp), .ext_osc_i(ext), .busy_o(busy), .done_o(done));
   lmcw_device #(.INT_OSC_DIV(4)) u_lmcw_device (.clk_sys_i, .rst_n_i, .link(link),
      .use_ext_osc_i(use_ext), .ser_out_o(ser_out), .brightness_sleep_word_o(w0),
      .output_mode_prescale_word_o(w1), .display_clk_en_o(clk_en), .row_on_o(row_on),
      .row_o(row), .peak_current_pct_o(pct), .refresh_done_o(refresh_done));
   lmcw_checker u_lmcw_checker (.clk_sys_i, .rst_n_i, .ser_clk(link.ser_clk),
      .ser_data(link.ser_data), .register_select(link.register_select),
      .chip_en_n(link.chip_en_n), .osc_out(link.osc_out));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // external oscillator, one rise every four cycles
   always @(negedge clk_sys_i) begin
      div <= ~div;
      if (div) ext <= ~ext;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string nm, input logic [9:0] ex, input logic [9:0] got);
      samples_checked++;
      if (got !== ex) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic test_done;
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one host write; pass-through seen live, serial output checked after
   task automatic send(input logic [7:0] w, input logic pm);
      int   i, h;
      logic thru;
      thru = e1[0];
      h = 0;
      @(negedge clk_sys_i);
      word = w;
      pass = pm;
      req  = 1'b1;
      @(negedge clk_sys_i);
      req = 1'b0;
      chk("busy", 10'h001, 10'(busy));
      if (w[7]) e1 = {5'h00, w[1:0]};
      else e0 = w[6:0];
      expq.push_back({e0, e1});
      for (i = 0; i < 200 && done !== 1'b1; i++) begin
         @(negedge clk_sys_i);
         h = link.ser_clk ? h + 1 : 0;
         if (thru && h == 4) chk("thru", 10'(link.ser_data), 10'(ser_out));
      end
      repeat (10) @(negedge clk_sys_i);
      chk("serial out", 10'(w[7]), 10'(ser_out));
      chk("busy idle", 10'h000, 10'(busy));
   endtask
   // display clocks and lit clocks over one whole refresh
   task automatic refresh(input int c);
      int n, lit;
      n = 0;
      lit = 0;
      @(negedge clk_sys_i iff refresh_done === 1'b1);
      do begin
         @(negedge clk_sys_i);
         n += int'(clk_en === 1'b1);
         lit += int'(clk_en === 1'b1 && row_on === 1'b1);
         if (clk_en === 1'b1 && n == 448) chk("row", 10'h007, 10'(row));
      end while (refresh_done !== 1'b1 && n < 600);
      chk("refresh", 10'h200, 10'(n));
      chk("on time", 10'(8 * on_t[c]), 10'(lit));
      chk("current", 10'(pct_t[c % 4]), 10'(pct));
   endtask
   task automatic spacing(output int r);
      r = 0;
      @(negedge clk_sys_i iff clk_en === 1'b1);
      do begin
         @(negedge clk_sys_i);
         r++;
      end while (clk_en !== 1'b1 && r < 300);
   endtask
   // word results are compared once each latch has landed
   always @(posedge done) begin
      logic [13:0] e;
      repeat (8) @(negedge clk_sys_i);
      e = expq.pop_front();
      chk("word0", 10'(e[13:7]), 10'(w0));
      chk("word1", 10'(e[6:0]), 10'(w1));
   end
   initial begin
      // about 68k cycles expected; give up at 90k
      #900000;
      n_fail++;
      test_done();
   end
   initial begin
      {req, pass, use_ext, lamp, rst_n_i} = 5'h00;
      {e0, e1} = 14'h0000;
      word = 8'h00;
      seed = 32'h0000004B;
      n_fail = 0;
      samples_checked = 0;
      repeat (6) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      chk("word0 reset", 10'h000, 10'(w0));
      chk("word1 reset", 10'h000, 10'(w1));
      use_ext = 1'b1;
      for (k = 0; k < 16; k++) begin
         send({2'b01, 2'(k), 4'(k)}, 1'b0);
         refresh(k);
      end
      for (k = 0; k < 6; k++) begin
         seed = xs(seed);
         send(seed[7:0], 1'b0);
      end
      send(8'h80, 1'b0);
      send(8'h0F, 1'b0);
      ra = 0;
      repeat (300) begin
         @(negedge clk_sys_i);
         ra += int'(row_on !== 1'b0);
      end
      chk("sleep lit", 10'h000, 10'(ra));
      send(8'h4F, 1'b0);
      // awake and full on-time, yet lamp-off must keep every row dark
      lamp = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      ra = 0;
      repeat (300) begin
         @(negedge clk_sys_i);
         ra += int'(row_on !== 1'b0);
      end
      lamp = 1'b0;
      chk("blank lit", 10'h000, 10'(ra));
      send(8'h82, 1'b0);
      spacing(ra);
      chk("prescale", 10'h020, 10'(ra));
      send(8'h80, 1'b0);
      spacing(ra);
      chk("direct", 10'h004, 10'(ra));
      use_ext = 1'b0;
      spacing(ra);
      send(8'h82, 1'b0);
      spacing(rb);
      chk("internal rate", 10'(ra), 10'(rb));
      send(8'h81, 1'b1);
      send(8'h4F, 1'b1);
      send(8'h80, 1'b1);
      test_done();
   end
endmodule // testbench
`default_nettype wire

//--- rtl/lmcw_device.sv
`default_nettype none
// Function
// - top bit picks word 0 or 1
// - host loads eight bits msb first, then latches
// - word0 bit6 low sleeps and blanks display
// - current code 00 gives 73 percent
// - word1 bit0 selects output mode, default serial
// - serial mode outputs shift register msb
// - pass-through copies input during control writes
// - host clocks n*8 or 8 per chain
// - prescale bit low uses external oscillator directly
// - prescale bit high divides external oscillator by eight
// - refresh takes 512 display clocks
// - prescaler never touches internal oscillator
// - host writes zero to word1 bits 2-6
// - two ICs chain into 320-bit dots
// - first IC left, second IC right
// - every IC gets its own control write
// - host buses control lines, data chains leftward
// - master drives oscillator, slaves take it
// - reset clears both words
module lmcw_device
   import lmcw_pkg::*;
#(
   parameter int unsigned INT_OSC_DIV = 500
) (
   input  wire logic   clk_sys_i,
   input  wire logic   rst_n_i,
   lmcw_if.device      link,
   input  wire logic   use_ext_osc_i,
   output logic        ser_out_o,
   output logic [6:0]  brightness_sleep_word_o,
   output logic [6:0]  output_mode_prescale_word_o,
   output logic        display_clk_en_o,
   output logic        row_on_o,
   output logic [2:0]  row_o,
   output logic [6:0]  peak_current_pct_o,
   output logic        refresh_done_o
);
   // the internal divider counts in 16 bits and needs at least two states
   if (INT_OSC_DIV < 2 || INT_OSC_DIV > 65535) begin : g_bad_div
      $error("bad INT_OSC_DIV");
   end

   typedef struct packed {
      logic [1:0]  clk_sy;
      logic [1:0]  dat_sy;
      logic [1:0]  rs_sy;
      logic [1:0]  ce_sy;
      logic [1:0]  xo_sy;
      logic [1:0]  lamp_sy;
      logic        clk_prev;
      logic        xo_prev;
      logic        ce_prev;
      logic        ctrl_sel;
      logic        armed;
      logic [7:0]  shift;
      logic [6:0]  word0;
      logic [6:0]  word1;
      logic [15:0] int_cnt;
      logic [2:0]  pre_cnt;
      logic [8:0]  ref_cnt;
      logic        dclk_en;
      logic        row_on;
      logic [6:0]  cur_pct;
      logic        ref_done;
      logic        sout;
      logic        osc_out;
   } lmcw_dev_type;

   lmcw_dev_type s_q;
   lmcw_dev_type s_d;

   logic       clk_s;
   logic       dat_s;
   logic       ce_s;
   logic       xo_s;
   logic       rise;
   logic       xo_rise;
   logic       osc_tick;
   logic [5:0] on_time;

   assign clk_s = s_q.clk_sy[1];
   assign dat_s = s_q.dat_sy[1];
   assign ce_s  = s_q.ce_sy[1];
   assign xo_s  = s_q.xo_sy[1];
   assign rise  = clk_s && !s_q.clk_prev;
   assign xo_rise = xo_s && !s_q.xo_prev;
   assign on_time = lmcw_on_time(s_q.word0[PWM_LSB +: 4]);

   // display timebase selection
   always_comb begin
      osc_tick = 1'b0;
      if (use_ext_osc_i) begin
         if (s_q.word1[PRESCALE_BIT]) begin
            osc_tick = xo_rise && (s_q.pre_cnt == 3'(PRESCALE_DIV - 1));
         end else begin
            osc_tick = xo_rise;
         end
      end else begin
         // internal source ignores the prescale bit
         osc_tick = s_q.word0[SLEEP_BIT] &&
                    (s_q.int_cnt == 16'(INT_OSC_DIV - 1));
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      // every link pin is asynchronous to this clock: two flops before use
      s_d.clk_sy = {s_q.clk_sy[0], link.ser_clk};
      s_d.dat_sy = {s_q.dat_sy[0], link.ser_data};
      s_d.rs_sy  = {s_q.rs_sy[0], link.register_select};
      s_d.ce_sy  = {s_q.ce_sy[0], link.chip_en_n};
      s_d.xo_sy  = {s_q.xo_sy[0], link.ext_osc};
      s_d.lamp_sy = {s_q.lamp_sy[0], link.lamp_off_input};
      s_d.clk_prev = clk_s;
      s_d.xo_prev  = xo_s;
      s_d.ce_prev  = ce_s;
      s_d.dclk_en  = 1'b0;
      s_d.ref_done = 1'b0;
      // selection on falling chip enable, register select sampled there
      if (s_q.ce_prev && !ce_s) begin
         s_d.ctrl_sel = s_q.rs_sy[1];
         s_d.armed    = 1'b0;
      end
      // shift on rising serial clock while enabled
      if (!ce_s && rise && s_q.ctrl_sel) begin
         s_d.shift = {s_q.shift[6:0], dat_s};
         s_d.armed = 1'b1;
      end
      // latch when enable high and clock low
      // waiting for a low clock keeps a late rise out of the copied word
      if (ce_s && !clk_s && s_q.armed && s_q.ctrl_sel) begin
         s_d.armed = 1'b0;
         if (s_q.shift[SEL_BIT]) begin
            s_d.word1 = s_q.shift[6:0];
         end else begin
            s_d.word0 = s_q.shift[6:0];
         end
      end
      // serial output source
      // pass-through only inside a control frame; dot loads keep the msb
      if (s_q.word1[PASS_BIT] && s_q.ctrl_sel && !ce_s) begin
         s_d.sout = dat_s;
      end else begin
         s_d.sout = s_q.shift[SEL_BIT];
      end
      // oscillators
      // sleep holds the internal divider at zero, so slaves on osc_out stop too
      if (s_q.int_cnt == 16'(INT_OSC_DIV - 1)) begin
         s_d.int_cnt = 16'h0000;
         s_d.osc_out = !s_q.osc_out;
      end else begin
         s_d.int_cnt = s_q.int_cnt + 16'h0001;
      end
      if (!s_q.word0[SLEEP_BIT]) begin
         s_d.int_cnt = 16'h0000;
      end
      // prescaler runs free; a mode change may shorten one display clock
      if (xo_rise) begin
         s_d.pre_cnt = s_q.pre_cnt + 3'h1;
      end
      // refresh sequencing
      // the count wraps at 512 ticks, so its top three bits name the row
      if (osc_tick) begin
         s_d.dclk_en = 1'b1;
         s_d.ref_cnt = s_q.ref_cnt + 9'h001;
         if (s_q.ref_cnt == 9'(REFRESH_CYCLES - 1)) begin
            s_d.ref_done = 1'b1;
         end
      end
      // lamp-off blanks at once but leaves the refresh count running
      s_d.row_on = s_q.word0[SLEEP_BIT] && !s_q.lamp_sy[1] &&
                   ({3'h0, s_q.ref_cnt[5:0]} < {3'h0, on_time});
      // current percent registered so it changes only with the control word
      case (s_q.word0[CUR_LSB +: 2])
         2'h0: s_d.cur_pct = CUR_PCT_00;
         2'h1: s_d.cur_pct = CUR_PCT_01;
         2'h2: s_d.cur_pct = CUR_PCT_10;
         default: s_d.cur_pct = CUR_PCT_11;
      endcase
   end

   // state register; reset zeroes both words
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         // chip enable idles high, so no false frame start after reset
         s_q.ce_sy <= 2'h3;
         s_q.ce_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // every output is read straight off the state register
   assign link.ser_out = s_q.sout;
   assign link.osc_out = s_q.osc_out;
   assign ser_out_o = s_q.sout;
   assign brightness_sleep_word_o = s_q.word0;
   assign output_mode_prescale_word_o = s_q.word1;
   assign display_clk_en_o = s_q.dclk_en;
   assign row_on_o = s_q.row_on;
   assign row_o = s_q.ref_cnt[8:6];
   assign peak_current_pct_o = s_q.cur_pct;
   assign refresh_done_o = s_q.ref_done;
endmodule // lmcw_device
`default_nettype wire

//--- rtl/lmcw_host.sv
`default_nettype none
// host end: shifts one control byte out, msb first
module lmcw_host
   import lmcw_pkg::*;
#(
   parameter int unsigned CHAIN_LEN = 1
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   lmcw_if.host            link,
   input  wire logic       req_i,
   input  wire logic [7:0] word_i,
   input  wire logic       pass_mode_i,
   input  wire logic       lamp_off_i,
   input  wire logic       ext_osc_i,
   output logic            busy_o,
   output logic            done_o
);
   // the check caps the chain at 32 words; the 9-bit bit counter would hold up to 63
   if (CHAIN_LEN < 1 || CHAIN_LEN > 32) begin : g_bad_chain
      $error("bad CHAIN_LEN");
   end

   typedef enum logic [1:0] {
      IDLE  = 2'b00,
      SEL   = 2'b01,
      SHIFT = 2'b10,
      LATCH = 2'b11
   } lmcw_st_type;

   typedef struct packed {
      lmcw_st_type st;
      logic [7:0]  word;
      logic [8:0]  bits;
      logic [3:0]  div;
      logic        sclk;
      logic        ce_n;
      logic        rs;
      logic        data;
      logic        done;
      logic        lamp;
      logic        xo;
      logic        busy;
   } lmcw_host_type;

   lmcw_host_type h_q;
   lmcw_host_type h_d;
   logic          half;
   logic [8:0]    total;

   assign half = (h_q.div == 4'(HOST_HALF_CYC - 1));
   // one word per chip unless pass-through lets one word reach all
   assign total = pass_mode_i ? 9'(CTRL_BITS) : 9'(CTRL_BITS * CHAIN_LEN);

   always_comb begin
      h_d = h_q;
      h_d.done = 1'b0;
      h_d.lamp = lamp_off_i;
      h_d.xo = ext_osc_i;
      h_d.div = half ? 4'h0 : h_q.div + 4'h1;
      case (h_q.st)
         IDLE: begin
            h_d.sclk = 1'b0;
            if (req_i) begin
               // zero bits 2-6 of word 1
               h_d.word = word_i[7] ? {word_i[7], 5'h00, word_i[1:0]} : word_i;
               h_d.rs = 1'b1;
               h_d.bits = 9'h000;
               h_d.div = 4'h0;
               h_d.st = SEL;
            end
         end
         SEL: if (half) begin
            h_d.ce_n = 1'b0;
            h_d.data = h_q.word[7];
            h_d.st = SHIFT;
         end
         SHIFT: if (half) begin
            h_d.sclk = !h_q.sclk;
            if (h_q.sclk) begin
               h_d.word = {h_q.word[6:0], h_q.word[7]};
               h_d.data = h_q.word[6];
               // bits counts rises, so the SHIFT state ends at the fall after the last one
               if (h_q.bits == total) begin
                  h_d.st = LATCH;
               end
            end else begin
               h_d.bits = h_q.bits + 9'h001;
            end
         end
         LATCH: if (half) begin
            h_d.ce_n = 1'b1;
            h_d.done = 1'b1;
            h_d.st = IDLE;
         end
         default: h_d.st = IDLE;
      endcase
      // busy registered so the output comes straight from a flop
      h_d.busy = (h_d.st != IDLE);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         h_q <= '0;
         h_q.ce_n <= 1'b1;
      end else begin
         h_q <= h_d;
      end
   end

   assign link.ser_clk = h_q.sclk;
   assign link.ser_data = h_q.data;
   assign link.register_select = h_q.rs;
   assign link.chip_en_n = h_q.ce_n;
   assign link.lamp_off_input = h_q.lamp;
   assign link.ext_osc = h_q.xo;
   assign busy_o = h_q.busy;
   assign done_o = h_q.done;
endmodule // lmcw_host
`default_nettype wire

//--- rtl/lmcw_if.sv
`default_nettype none
interface lmcw_if;
   logic ser_clk;
   logic ser_data;
   logic register_select;
   logic chip_en_n;
   logic lamp_off_input;
   logic ser_out;
   logic ext_osc;
   logic osc_out;
   modport host (
      output ser_clk, ser_data, register_select, chip_en_n, lamp_off_input, ext_osc,
      input  ser_out, osc_out
   );
   modport device (
      input  ser_clk, ser_data, register_select, chip_en_n, lamp_off_input, ext_osc,
      output ser_out, osc_out
   );
endinterface
`default_nettype wire

//--- rtl/lmcw_pkg.sv
`default_nettype none
package lmcw_pkg;
   // control shift register layout
   localparam int unsigned CTRL_BITS      = 8;
   localparam int unsigned WORD_BITS      = 7;
   localparam int unsigned SEL_BIT        = 7;
   // word 0 fields
   localparam int unsigned SLEEP_BIT      = 6;
   localparam int unsigned CUR_LSB        = 4;
   localparam int unsigned PWM_LSB        = 0;
   // word 1 fields
   localparam int unsigned PASS_BIT       = 0;
   localparam int unsigned PRESCALE_BIT   = 1;
   localparam logic [6:0]  WORD_RESET     = 7'h00;
   // refresh timing
   localparam int unsigned ROW_CYCLES     = 64;
   localparam int unsigned ROWS           = 8;
   localparam int unsigned REFRESH_CYCLES = ROW_CYCLES * ROWS;
   localparam int unsigned PRESCALE_DIV   = 8;
   localparam int unsigned DOTS_PER_IC    = 160;
   // host serial clock half period in system cycles
   localparam int unsigned HOST_HALF_CYC  = 5;
   // peak current codes, percent of full scale
   localparam logic [6:0]  CUR_PCT_00     = 7'h49;
   localparam logic [6:0]  CUR_PCT_01     = 7'h32;
   localparam logic [6:0]  CUR_PCT_10     = 7'h1F;
   localparam logic [6:0]  CUR_PCT_11     = 7'h64;

   // on-time per row in display clock cycles for each pwm code
   function automatic logic [5:0] lmcw_on_time(input logic [3:0] code);
      logic [5:0] t;
      t = 6'h00;
      case (code)
         4'h0: t = 6'h00;
         4'h1: t = 6'h01;
         4'h2: t = 6'h02;
         4'h3: t = 6'h03;
         4'h4: t = 6'h04;
         4'h5: t = 6'h05;
         4'h6: t = 6'h07;
         4'h7: t = 6'h09;
         4'h8: t = 6'h0B;
         4'h9: t = 6'h0E;
         4'hA: t = 6'h12;
         4'hB: t = 6'h16;
         4'hC: t = 6'h1C;
         4'hD: t = 6'h24;
         4'hE: t = 6'h30;
         default: t = 6'h3C;
      endcase
      return t;
   endfunction
endpackage
`default_nettype wire
